// file: pkg/shsp_pkg.sv
// shared constants, carriers and address helpers of the serial port
package shsp_pkg;
    localparam int ADDR_W = 7; // register address width
    localparam int DATA_W = 8; // register data width

    // incrementing lines of the register map
    localparam logic [6:0] LO_FIRST = 7'h00; // low group start
    localparam logic [6:0] LO_GAP_LAST = 7'h03; // last address before the gap
    localparam logic [6:0] LO_GAP_NEXT = 7'h10; // first address after the gap
    localparam logic [6:0] LO_LAST = 7'h18; // low group end
    localparam logic [6:0] LO_FIFO_WRAP = 7'h11; // low group wrap with fifo on
    localparam logic [6:0] CTL_FIRST = 7'h30; // control group start
    localparam logic [6:0] CTL_LAST = 7'h32; // control group wrap point
    localparam logic [6:0] CTL_MAP_LAST = 7'h37; // last selected control address
    localparam logic [6:0] UP_FIRST = 7'h60; // upper group start
    localparam logic [6:0] UP_LAST = 7'h62; // upper group end

    // i2c byte patterns
    localparam logic [4:0] I2C_ADDR_HI = 5'h03; // fixed upper target address bits
    localparam logic [4:0] HS_CODE_HI = 5'h01; // upper bits of the high-speed master code
    localparam logic [3:0] I2C_BITS = 4'h8; // bits in one byte

    // spi frame bit counts (value of the counter before the edge)
    localparam logic [4:0] SPI_ADDR_BIT = 5'h07; // edge that completes the header
    localparam logic [4:0] SPI_LAST_BIT = 5'h0f; // edge that completes the frame
    localparam logic [4:0] SPI_CNT_MAX = 5'h1f; // counter top during long reads
    localparam logic [4:0] SPI_CNT_REARM = 5'h10; // counter restart in long reads

    // event handed from the serial clock domain to mclk
    typedef struct packed {
        logic wr; // one for a write, zero for a read step
        logic [6:0] addr; // register address
        logic [7:0] data; // write data
    } shsp_evt_t;

    // request toward the register file
    typedef struct packed {
        logic we; // one-cycle write strobe
        logic rd; // one-cycle read strobe
        logic [6:0] addr; // register address
        logic [7:0] wdata; // write data
    } shsp_req_t;

    // next address in the auto-increment lines
    function automatic logic [6:0] shsp_next_addr(input logic [6:0] a, input logic fifo_on);
        logic [6:0] n;
        n = 7'(a + 7'h01);
        if (a == LO_GAP_LAST) n = LO_GAP_NEXT;
        if (a == LO_LAST) n = fifo_on ? LO_FIFO_WRAP : LO_FIRST;
        if (a == CTL_LAST) n = CTL_FIRST;
        if (a == UP_LAST) n = UP_FIRST;
        return n;
    endfunction : shsp_next_addr

    // address selects this device on spi
    function automatic logic shsp_in_map(input logic [6:0] a);
        return (a <= LO_LAST) || (a >= CTL_FIRST && a <= CTL_MAP_LAST) || (a >= UP_FIRST && a <= UP_LAST);
    endfunction : shsp_in_map

    // address holds a writable register
    function automatic logic shsp_writable(input logic [6:0] a);
        return a >= CTL_FIRST && a <= CTL_MAP_LAST;
    endfunction : shsp_writable
endpackage : shsp_pkg

// file: src/shsp_port.sv
// What this block does
// - low select pin spi, high select i2c
// - spi frame is rw, address, data
// - spi samples rising, shifts out falling
// - frame spans chip select low
// - spi write stores second byte
// - short write frames write nothing
// - one spi write per frame
// - spi read shifts register out msb first
// - continued spi clocks read next address
// - serial output floats when deselected
// - low group skips gap, wraps by fifo
// - control and upper groups wrap
// - unmapped spi address keeps output floating
// - i2c runs standard, fast, high speed
// - match target address, acknowledge, else silent
// - target address from two straps
// - address lsb picks read or write
// - i2c write: register address, then data
// - further write bytes go to next address
// - only writable registers change
// - i2c read continues on host acknowledge
// - master code arms high speed mode
// - counter holds address after last access
`timescale 1ns/1ps
`default_nettype none
module shsp_port (
    input wire logic mclk, // system clock
    input wire logic rst, // reset, active high; synchronous in mclk, asynchronous in the serial clock domain
    input wire logic chip_select_n, // spi select, high selects i2c
    input wire logic serial_clock_in, // spi clock and i2c clock pin
    input wire logic data_pin_in, // spi data in and i2c data level
    output logic data_pin_out, // i2c data drive level
    output logic data_pin_oe, // i2c data drive enable
    output logic spi_so_out, // spi serial output level
    output logic spi_so_oe, // spi serial output enable
    input wire logic addr_strap_bit0, // target address strap 0
    input wire logic addr_strap_bit1, // target address strap 1
    input wire logic fifo_en, // fifo enable from the register file
    output shsp_pkg::shsp_req_t reg_req, // register request, mclk domain
    input wire logic [7:0] reg_rdata, // register data at reg_req.addr
    output logic [6:0] spi_rd_addr, // spi read address, serial clock domain
    input wire logic [7:0] spi_rd_data, // register data at spi_rd_addr
    output logic i2c_hs_mode // high speed i2c in force
);
    import shsp_pkg::*;

    // ---------------- serial clock domain: spi ----------------
    logic [4:0] spi_cnt_reg; // rising edges seen in this frame, rearmed from 31 to 16
    logic [7:0] spi_sh_reg; // input shift register
    logic spi_rw_reg; // frame is a read
    logic spi_sel_reg; // header address selects us
    logic [6:0] spi_addr_reg; // frame address, advances on reads
    shsp_evt_t spi_evt_reg; // event word for mclk
    logic spi_tgl_reg; // flips once per event
    logic [1:0] fifo_sk_reg; // fifo enable synchroniser
    logic [7:0] spi_out_reg; // output shift register
    logic spi_drv_reg; // output byte is being driven

    // decode of the current rising edge
    wire [7:0] spi_sh_next = {spi_sh_reg[6:0], data_pin_in};
    wire [6:0] spi_hdr_addr = spi_sh_next[6:0];
    wire spi_at_addr = spi_cnt_reg == SPI_ADDR_BIT;
    wire spi_at_last = spi_cnt_reg == SPI_LAST_BIT;
    wire spi_hdr_rd = spi_at_addr && spi_sh_next[7] && shsp_in_map(spi_hdr_addr);
    wire spi_rd_step = spi_rw_reg && spi_sel_reg && spi_cnt_reg[2:0] == 3'h7 && spi_cnt_reg > SPI_ADDR_BIT;
    wire spi_wr_done = spi_at_last && !spi_rw_reg && spi_sel_reg;
    wire [6:0] spi_step_addr = shsp_next_addr(spi_addr_reg, fifo_sk_reg[1]);
    wire [4:0] spi_cnt_next = (spi_cnt_reg == SPI_CNT_MAX) ? SPI_CNT_REARM : 5'(spi_cnt_reg + 5'h01);
    wire spi_load = spi_rw_reg && spi_sel_reg && spi_cnt_reg[2:0] == 3'h0 && spi_cnt_reg > SPI_ADDR_BIT;

    // frame state, cleared while chip select is high
    always_ff @(posedge serial_clock_in or posedge chip_select_n) begin
        if (chip_select_n) begin
            spi_cnt_reg <= 5'h00;
            spi_sh_reg <= 8'h00;
            spi_rw_reg <= 1'b0;
            spi_sel_reg <= 1'b0;
        end else begin
            spi_cnt_reg <= spi_cnt_next;
            spi_sh_reg <= spi_sh_next;
            if (spi_at_addr) begin // header complete
                spi_rw_reg <= spi_sh_next[7];
                spi_sel_reg <= shsp_in_map(spi_hdr_addr);
            end
        end
    end

    // address, event word and toggle survive between frames
    always_ff @(posedge serial_clock_in or posedge rst) begin
        if (rst) begin
            spi_addr_reg <= 7'h00;
            spi_evt_reg <= '0;
            spi_tgl_reg <= 1'b0;
            fifo_sk_reg <= 2'h0;
        end else begin
            fifo_sk_reg <= {fifo_sk_reg[0], fifo_en}; // two-flop crossing
            if (spi_at_addr && !chip_select_n) begin // header address
                spi_addr_reg <= spi_hdr_addr;
            end
            if (chip_select_n) begin
                // clocks while deselected carry nothing
            end else if (spi_hdr_rd) begin // first read byte
                spi_evt_reg <= '{wr: 1'b0, addr: spi_hdr_addr, data: 8'h00};
                spi_tgl_reg <= ~spi_tgl_reg;
            end else if (spi_rd_step) begin // next byte of a long read
                spi_addr_reg <= spi_step_addr;
                spi_evt_reg <= '{wr: 1'b0, addr: spi_step_addr, data: 8'h00};
                spi_tgl_reg <= ~spi_tgl_reg;
            end else if (spi_wr_done) begin // sixteenth edge of a write
                spi_evt_reg <= '{wr: 1'b1, addr: spi_addr_reg, data: spi_sh_next};
                spi_tgl_reg <= ~spi_tgl_reg;
            end
        end
    end

    // output byte changes on falling edges
    always_ff @(negedge serial_clock_in or posedge chip_select_n) begin
        if (chip_select_n) begin
            spi_out_reg <= 8'h00;
            spi_drv_reg <= 1'b0;
        end else if (spi_load) begin // byte boundary of a read
            spi_out_reg <= spi_rd_data;
            spi_drv_reg <= 1'b1;
        end else begin
            spi_out_reg <= {spi_out_reg[6:0], 1'b0};
        end
    end

    // output floats unless selected and reading
    assign spi_so_out = spi_out_reg[7];
    assign spi_so_oe = spi_drv_reg && !chip_select_n;
    assign spi_rd_addr = spi_addr_reg;

    // ---------------- mclk domain ----------------
    typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_TX, I_TXACK} shsp_i2c_st_t;
    typedef enum logic [1:0] {K_DEV, K_REG, K_DAT} shsp_kind_t;

    logic [1:0] cs_sync_reg; // select pin synchroniser
    logic [2:0] scl_sync_reg; // clock pin synchroniser and delay
    logic [2:0] sda_sync_reg; // data pin synchroniser and delay
    logic [1:0] strap0_sync_reg; // strap 0 synchroniser
    logic [1:0] strap1_sync_reg; // strap 1 synchroniser
    logic [2:0] tgl_sync_reg; // event toggle synchroniser and delay
    shsp_i2c_st_t st_reg; // i2c state
    shsp_kind_t kind_reg; // meaning of the byte being received
    logic [3:0] bitc_reg; // bits of the current byte
    logic [7:0] sh_reg; // i2c shift register
    logic oe_reg; // pulls the data line low
    logic to_tx_reg; // acknowledge leads into a read byte
    logic mack_reg; // host acknowledged the last byte
    logic hs_arm_reg; // master code seen
    logic hs_mode_reg; // high speed in force
    logic [6:0] ptr_reg; // internal address counter
    shsp_req_t req_reg; // register request

    // pin synchronisers
    always_ff @(posedge mclk) begin
        if (rst) begin
            cs_sync_reg <= 2'h0;
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            strap0_sync_reg <= 2'h0;
            strap1_sync_reg <= 2'h0;
            tgl_sync_reg <= 3'h0;
        end else begin
            cs_sync_reg <= {cs_sync_reg[0], chip_select_n};
            scl_sync_reg <= {scl_sync_reg[1:0], serial_clock_in};
            sda_sync_reg <= {sda_sync_reg[1:0], data_pin_in};
            strap0_sync_reg <= {strap0_sync_reg[0], addr_strap_bit0};
            strap1_sync_reg <= {strap1_sync_reg[0], addr_strap_bit1};
            tgl_sync_reg <= {tgl_sync_reg[1:0], spi_tgl_reg};
        end
    end

    // bus conditions seen on synchronised levels
    wire i2c_on = cs_sync_reg[1];
    wire scl_now = scl_sync_reg[1];
    wire scl_old = scl_sync_reg[2];
    wire sda_now = sda_sync_reg[1];
    wire sda_old = sda_sync_reg[2];
    wire scl_rise = scl_now && !scl_old;
    wire scl_fall = !scl_now && scl_old;
    wire i2c_start = i2c_on && scl_now && scl_old && !sda_now && sda_old;
    wire i2c_stop = i2c_on && scl_now && scl_old && sda_now && !sda_old;
    wire [6:0] my_addr = {I2C_ADDR_HI, strap1_sync_reg[1], strap0_sync_reg[1]};
    wire byte_done = scl_fall && bitc_reg == I2C_BITS;
    wire dev_hit = sh_reg[7:1] == my_addr;
    wire hs_code = sh_reg[7:3] == HS_CODE_HI;
    wire spi_pulse = tgl_sync_reg[1] ^ tgl_sync_reg[2];
    wire i2c_wr = st_reg == I_RX && kind_reg == K_DAT && byte_done;
    wire i2c_reg = st_reg == I_RX && kind_reg == K_REG && byte_done;
    wire i2c_load = scl_fall && ((st_reg == I_ACK && to_tx_reg) || (st_reg == I_TXACK && mack_reg));
    wire [6:0] ptr_step = shsp_next_addr(ptr_reg, fifo_en);

    // address counter and register strobes
    always_ff @(posedge mclk) begin
        if (rst) begin
            ptr_reg <= 7'h00;
            req_reg <= '0;
        end else if (spi_pulse) begin // event from the spi side
            req_reg.we <= spi_evt_reg.wr && shsp_writable(spi_evt_reg.addr);
            req_reg.rd <= !spi_evt_reg.wr;
            req_reg.addr <= spi_evt_reg.addr;
            req_reg.wdata <= spi_evt_reg.data;
            ptr_reg <= shsp_next_addr(spi_evt_reg.addr, fifo_en);
        end else begin
            req_reg.we <= i2c_wr && shsp_writable(ptr_reg);
            req_reg.rd <= i2c_load;
            req_reg.addr <= ptr_reg;
            req_reg.wdata <= sh_reg;
            if (i2c_reg) begin // register address byte
                ptr_reg <= sh_reg[6:0];
            end else if (i2c_wr || i2c_load) begin
                ptr_reg <= ptr_step;
            end
        end
    end

    // i2c target state machine
    always_ff @(posedge mclk) begin
        if (rst || !i2c_on) begin
            st_reg <= I_IDLE;
            kind_reg <= K_DEV;
            bitc_reg <= 4'h0;
            sh_reg <= 8'h00;
            oe_reg <= 1'b0;
            to_tx_reg <= 1'b0;
            mack_reg <= 1'b0;
            hs_arm_reg <= 1'b0;
            hs_mode_reg <= 1'b0;
        end else if (i2c_start) begin // start or repeated start
            st_reg <= I_RX;
            kind_reg <= K_DEV;
            bitc_reg <= 4'h0;
            oe_reg <= 1'b0;
            hs_mode_reg <= hs_arm_reg;
            hs_arm_reg <= 1'b0;
        end else if (i2c_stop) begin // stop leaves high speed
            st_reg <= I_IDLE;
            oe_reg <= 1'b0;
            hs_mode_reg <= 1'b0;
        end else begin
            unique case (st_reg)
                I_IDLE: begin
                    oe_reg <= 1'b0; // wait for a start
                end
                I_RX: begin
                    if (scl_rise) begin // sample one bit
                        sh_reg <= {sh_reg[6:0], sda_now};
                        bitc_reg <= 4'(bitc_reg + 4'h1);
                    end else if (byte_done) begin
                        bitc_reg <= 4'h0;
                        if (kind_reg != K_DEV) begin // register or data byte
                            st_reg <= I_ACK;
                            oe_reg <= 1'b1;
                            to_tx_reg <= 1'b0;
                            kind_reg <= K_DAT;
                        end else if (dev_hit) begin // addressed
                            st_reg <= I_ACK;
                            oe_reg <= 1'b1;
                            to_tx_reg <= sh_reg[0];
                            kind_reg <= K_REG;
                        end else begin // not us: stay silent
                            hs_arm_reg <= hs_code;
                            st_reg <= I_IDLE;
                        end
                    end
                end
                I_ACK: begin
                    if (scl_fall && to_tx_reg) begin // first read byte
                        st_reg <= I_TX;
                        sh_reg <= reg_rdata;
                        oe_reg <= !reg_rdata[7];
                        bitc_reg <= 4'h0;
                    end else if (scl_fall) begin // back to receiving
                        st_reg <= I_RX;
                        oe_reg <= 1'b0;
                    end
                end
                I_TX: begin
                    if (scl_rise) begin
                        bitc_reg <= 4'(bitc_reg + 4'h1);
                    end else if (scl_fall && bitc_reg == I2C_BITS) begin
                        oe_reg <= 1'b0;
                        st_reg <= I_TXACK;
                    end else if (scl_fall) begin // next bit
                        sh_reg <= {sh_reg[6:0], 1'b0};
                        oe_reg <= !sh_reg[6];
                    end
                end
                I_TXACK: begin
                    if (scl_rise) begin // host answer
                        mack_reg <= !sda_now;
                    end else if (scl_fall && mack_reg) begin // continue reading
                        st_reg <= I_TX;
                        sh_reg <= reg_rdata;
                        oe_reg <= !reg_rdata[7];
                        bitc_reg <= 4'h0;
                    end else if (scl_fall) begin // no acknowledge: stop
                        st_reg <= I_IDLE;
                    end
                end
            endcase
        end
    end

    // open-drain data line and outputs
    assign data_pin_out = 1'b0;
    assign data_pin_oe = oe_reg;
    assign reg_req = req_reg;
    assign i2c_hs_mode = hs_mode_reg;
endmodule : shsp_port
`default_nettype wire

// file: testbench/shsp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module shsp_host_model (
    output logic cs_n, // chip select, low for spi
    output logic sk, // spi clock and scl
    output logic pin, // si level, or sda drive where one releases
    input wire logic so, // spi serial output line
    input wire logic sda // resolved sda line
);
    localparam int HALF = 24; // half of the 48 ns link clock
    localparam int Q = 625; // quarter scl period, 400 khz
    logic [15:0] res; // last result: kind, then value
    event res_ev; // a result is ready
    // idle: clock high, sda released
    initial begin
        cs_n = 1'b1;
        sk = 1'b1;
        pin = 1'b1;
    end
    // mode 3 frame; junk bits past the sixteenth
    task automatic spi_frame(input logic [15:0] w, input int nclk, input logic grab);
        logic [7:0] b;
        cs_n = 1'b0; // sk high at select edges
        for (int i = 0; i < nclk; i++) begin
            #HALF sk = 1'b0;
            pin = (i < 16) ? w[15 - i] : ~pin; // rw, address, data
            #HALF sk = 1'b1;
            b = {b[6:0], so}; // rising edge
            if (grab && i % 8 == 7 && i > 8) begin
                res = {8'h01, b};
                -> res_ev;
            end
        end
        #HALF cs_n = 1'b1;
        #500; // si holds while deselected
    endtask : spi_frame
    // one i2c bit, data moves with scl low
    task automatic i2c_bit(input logic v, output logic r);
        pin = v;
        #Q sk = 1'b1;
        #Q r = sda;
        #Q sk = 1'b0;
        #Q;
    endtask : i2c_bit
    // (repeated) start
    task automatic i2c_start();
        sk = 1'b0;
        #Q pin = 1'b1;
        #Q sk = 1'b1;
        #Q pin = 1'b0;
        #Q sk = 1'b0;
        #Q;
    endtask : i2c_start
    // stop
    task automatic i2c_stop();
        pin = 1'b0;
        #Q sk = 1'b1;
        #Q pin = 1'b1;
        #Q;
    endtask : i2c_stop
    // send a byte, report the acknowledge
    task automatic i2c_wr(input logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) i2c_bit(v[i], r);
        i2c_bit(1'b1, r);
        res = {8'h02, 7'h00, !r};
        -> res_ev;
    endtask : i2c_wr
    // fetch a byte, acknowledge for more
    task automatic i2c_rd(input logic ack);
        logic [7:0] v;
        logic r;
        for (int i = 7; i >= 0; i--) begin
            i2c_bit(1'b1, r);
            v[i] = r;
        end
        i2c_bit(!ack, r);
        res = {8'h01, v};
        -> res_ev;
    endtask : i2c_rd
endmodule : shsp_host_model
`default_nettype wire

// file: testbench/shsp_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module shsp_port_asserts (
    input wire logic mclk, // clock
    input wire logic rst, // reset
    input wire logic chip_select_n, // spi select
    input wire logic serial_clock_in, // sck and scl
    input wire logic data_pin_in, // si and sda
    input wire logic data_pin_oe, // sda pull
    input wire logic spi_so_oe, // so enable
    input wire shsp_pkg::shsp_req_t reg_req, // request
    input wire logic [6:0] spi_rd_addr, // spi address
    input wire logic i2c_hs_mode // high speed
);
    // so floats when deselected
    a_so_float_desel: assert property (@(posedge mclk) disable iff (rst)
        chip_select_n |-> !spi_so_oe) else $error("so driven deselected");
    // no sda pull in spi
    a_spi_sda_quiet: assert property (@(posedge mclk) disable iff (rst)
        !chip_select_n [*4] |-> !data_pin_oe) else $error("sda pulled in spi");
    // writes hit writable places only
    a_we_writable: assert property (@(posedge mclk) disable iff (rst)
        reg_req.we |-> reg_req.addr inside {[7'h30:7'h37]}) else $error("write to read-only");
    // one-cycle strobes
    a_strobe_single: assert property (@(posedge mclk) disable iff (rst)
        (reg_req.we || reg_req.rd) |=> !(reg_req.we || reg_req.rd)) else $error("strobe held");
    // sda pull starts after scl fell
    a_ack_after_fall: assert property (@(posedge mclk) disable iff (rst)
        $rose(data_pin_oe) |-> !serial_clock_in && !$past(serial_clock_in, 2)) else $error("sda pulled near scl");
    // sda still while scl high
    a_sda_hold_high: assert property (@(posedge mclk) disable iff (rst)
        chip_select_n && serial_clock_in && $past(serial_clock_in) |-> $stable(data_pin_oe))
        else $error("sda moved, scl high");
    // stop ends high speed
    a_hs_stop_clear: assert property (@(posedge mclk) disable iff (rst)
        chip_select_n && serial_clock_in && $past(serial_clock_in) && $rose(data_pin_in)
        |-> ##[1:8] !i2c_hs_mode) else $error("high speed kept");
    // reset quiets outputs
    a_reset_quiet: assert property (@(posedge mclk)
        rst |=> reg_req == '0 && !data_pin_oe && !i2c_hs_mode) else $error("reset left state");
    // so drives mapped places only
    a_so_in_map: assert property (@(posedge serial_clock_in) disable iff (rst)
        spi_so_oe |-> spi_rd_addr inside {[7'h00:7'h18], [7'h30:7'h37], [7'h60:7'h62]})
        else $error("so for unmapped address");
endmodule : shsp_port_asserts
bind shsp_port shsp_port_asserts u_asserts (.*);
`default_nettype wire

// file: testbench/shsp_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module shsp_port_tb;
    import shsp_pkg::*;
    logic mclk = 1'b0; // system clock
    logic rst = 1'b0; // sync reset
    logic fifo_en = 1'b0; // fifo enable level
    logic addr_strap_bit0 = 1'b0; // address strap 0
    logic addr_strap_bit1 = 1'b0; // address strap 1
    logic cs_n, sk, pin; // host pin drives
    logic data_pin_out, data_pin_oe, spi_so_out, spi_so_oe, i2c_hs_mode; // port outputs
    wire logic din; // resolved data pin
    wire logic so; // resolved so line
    shsp_req_t reg_req; // register request
    logic [6:0] spi_rd_addr; // spi read address
    logic [7:0] mem [128]; // register file
    logic [15:0] exp_res [$]; // expected host results
    logic [15:0] exp_wr [$]; // expected register writes
    logic [6:0] rtab [5] = '{7'h16, 7'h18, 7'h62, 7'h03, 7'h32}; // spi read starts
    logic so_seen = 1'b0; // so was driven
    int n_errors = 0; // mismatches
    int compares = 0; // comparisons
    integer seed = 32'h9198; // random seed
    logic [7:0] d, d2; // random data
    logic [6:0] a; // walking address
    // sda pulled up; si from host
    assign din = cs_n ? (pin & !data_pin_oe) : pin;
    assign so = spi_so_oe ? spi_so_out : 1'bz;
    always #25 mclk = ~mclk;
    shsp_port dut (.mclk, .rst, .chip_select_n(cs_n), .serial_clock_in(sk), .data_pin_in(din), .data_pin_out,
        .data_pin_oe, .spi_so_out, .spi_so_oe, .addr_strap_bit0, .addr_strap_bit1, .fifo_en, .reg_req,
        .reg_rdata(mem[reg_req.addr]), .spi_rd_addr, .spi_rd_data(mem[spi_rd_addr]), .i2c_hs_mode);
    shsp_host_model host (.cs_n, .sk, .pin, .so, .sda(din));
    // expected increment lines
    function automatic logic [6:0] nxt(input logic [6:0] x, input logic f);
        case (x)
            7'h03: return 7'h10;
            7'h18: return f ? 7'h11 : 7'h00;
            7'h32: return 7'h30;
            7'h62: return 7'h60;
            default: return 7'(x + 7'h01);
        endcase
    endfunction : nxt
    task automatic check_res(input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t result exp=%h got=%h", $time, e, g);
        end
    endtask : check_res
    task automatic check_wr(input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t write exp=%h got=%h", $time, e, g);
        end
    endtask : check_wr
    // i2c byte out or in, noting its result
    task automatic iw(input logic [7:0] v, input logic ack);
        exp_res.push_back({8'h02, 7'h00, ack});
        host.i2c_wr(v);
    endtask : iw
    task automatic ir(input logic [6:0] x, input logic ack);
        exp_res.push_back({8'h01, mem[x]});
        host.i2c_rd(ack);
    endtask : ir
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // register file and write checks
    always @(posedge mclk) begin
        if (spi_so_oe === 1'b1) so_seen <= 1'b1;
        if (reg_req.we === 1'b1) begin
            mem[reg_req.addr] <= reg_req.wdata;
            check_wr(exp_wr.size() ? exp_wr.pop_front() : 16'hffff, {1'b0, reg_req.addr, reg_req.wdata});
        end
    end
    // host results vs oldest note
    always begin
        @(host.res_ev);
        check_res(exp_res.size() ? exp_res.pop_front() : 16'hffff, host.res);
    end
    initial begin
        rst <= 1'b1;
        for (int i = 0; i < 128; i++) mem[i] = 8'($random(seed));
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        #10;
        check_res(16'h0000, {reg_req.we, reg_req.rd, 6'h00, data_pin_oe, i2c_hs_mode, 6'h00});
        // i2c writes per strap, then a foreign address
        for (int s = 0; s < 4; s++) begin
            {addr_strap_bit1, addr_strap_bit0} <= 2'(s);
            d = 8'($random(seed));
            d2 = 8'($random(seed));
            repeat (4) @(posedge mclk);
            host.i2c_start();
            iw({5'h03, 2'(s), 1'b0}, 1'b1);
            iw(8'h32, 1'b1);
            exp_wr.push_back({1'b0, 7'h32, d});
            iw(d, 1'b1);
            exp_wr.push_back({1'b0, 7'h30, d2});
            iw(d2, 1'b1);
            exp_wr.push_back({1'b0, 7'h31, 8'h10});
            iw(8'h10, 1'b1);
            host.i2c_stop();
            host.i2c_start();
            iw({5'h03, ~2'(s), 1'b0}, 1'b0);
            host.i2c_stop();
        end
        $display("test i2c write done");
        // spi writes: plain, short, long, read-only
        exp_wr.push_back({1'b0, 7'h31, d});
        host.spi_frame({1'b0, 7'h31, d}, 16, 1'b0);
        host.spi_frame({1'b0, 7'h36, d2}, 12, 1'b0);
        exp_wr.push_back({1'b0, 7'h36, d});
        host.spi_frame({1'b0, 7'h36, d}, 24, 1'b0);
        host.spi_frame({1'b0, 7'h12, d}, 16, 1'b0);
        $display("test spi write done");
        // spi reads over each wrap
        foreach (rtab[i]) begin
            fifo_en <= i[0];
            repeat (4) @(posedge mclk);
            a = rtab[i];
            for (int k = 0; k < 4; k++) begin
                exp_res.push_back({8'h01, mem[a]});
                a = nxt(a, i[0]);
            end
            host.spi_frame({1'b1, rtab[i], 8'h00}, 40, 1'b1);
        end
        so_seen = 1'b0;
        host.spi_frame({1'b1, 7'h40, 8'h00}, 24, 1'b0);
        check_res(16'h0000, {15'h0000, so_seen});
        $display("test spi read done");
        // i2c random then current address read
        fifo_en <= 1'b1;
        host.i2c_start();
        iw(8'h1e, 1'b1);
        iw(8'h17, 1'b1);
        host.i2c_start();
        iw(8'h1f, 1'b1);
        ir(7'h17, 1'b1);
        ir(7'h18, 1'b1);
        ir(7'h11, 1'b0);
        host.i2c_stop();
        host.i2c_start();
        iw(8'h1f, 1'b1);
        ir(7'h12, 1'b0);
        host.i2c_stop();
        $display("test i2c read done");
        // master code arms high speed until stop
        host.i2c_start();
        iw(8'h09, 1'b0);
        host.i2c_start();
        check_res(16'h0001, {15'h0000, i2c_hs_mode});
        iw(8'h1e, 1'b1);
        host.i2c_stop();
        repeat (10) @(posedge mclk);
        #10;
        check_res(16'h0000, {15'h0000, i2c_hs_mode});
        $display("test high speed done");
        repeat (40) @(posedge mclk);
        check_wr(16'h0000, 16'(exp_wr.size()));
        check_res(16'h0000, 16'(exp_res.size()));
        end_of_test();
    end
    // watchdog
    initial begin
        #3000000;
        n_errors++;
        end_of_test();
    end
endmodule : shsp_port_tb
`default_nettype wire
